// File: hdl/mmdec_top.sv
// Memory and I/O map decoder for the unified 16-Mbyte space
// Contract
// - With unmap bit clear, FE0000h..FFFFFFh goes to on-chip ROM.
// - With unmap bit set, that range goes to external select five.
// - Hardware reset always clears the ROM-unmap bit.
// - Software reset leaves the ROM-unmap bit unchanged.
// - ROM is four 16K-word blocks, one zero-wait read each per cycle.
// - ROM reachable from CPU program and data buses.
// - I/O space is separate, selected by I/O opcodes or DMA.
// - I/O windows: idle control, DMA0 0x0C00-0x0C7F, system control 0x1C00.
// - I/O 0x7000-0x70FF is analog converter, 0x8000-0xFFFF is USB.
// - DMA controllers may reach the listed peripheral I/O windows.
// - External space from 050000h splits into five select spaces.
// - Each external space asserts its own select line on access.
// - External port: 16- or 8-bit data, 21-bit address, five selects.
// - Dual-access RAM is 8 blocks of 8K bytes, two accesses per cycle.
// - Single-access RAM is 32 blocks of 8K bytes, one access per cycle.
// - Lowest 192 bytes reserved; dual-access RAM starts at 0000C0h.
// - SDRAM select space starts 050000h, 8M less 320K bytes.
// - Async selects two..five start 800000h, C00000h, E00000h, F00000h.
// - Only DMA controller 3 may access external memory.
// - USB DMA and host port denied dual-access RAM.
// - SDRAM space uses select one alone or selects one and two.
`timescale 1ns/1ps
module mmdec_top
  import mmdec_pkg::*;
#(
  parameter int EXT_DBITS = 16
) (
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  // Status register three bit control
  input  wire logic                         unmap_wr_i,
  input  wire logic                         unmap_val_i,
  input  wire logic                         soft_reset_i,
  input  wire logic                         ext_byte_mode_i,
  input  wire logic                         sdram_dual_sel_i,
  // Access request, one per cycle
  input  wire logic                         req_i,
  input  wire logic                         we_i,
  input  wire logic                         io_space_i,
  input  wire logic                         prog_bus_i,
  input  wire logic [2:0]                   master_i,
  input  wire logic [23:0]                  addr_i,
  input  wire logic [15:0]                  wdata_i,
  // Read data offered by the addressed target
  input  wire logic [15:0]                  tgt_rdata_i,
  // Registered routing results
  output logic                              rom_unmap_bit_o,
  output logic                              ack_o,
  output logic                              deny_o,
  output logic [15:0]                       rdata_o,
  output logic [MMDEC_DA_BLOCKS-1:0]        dual_access_ram_sel_o,
  output logic [MMDEC_SA_BLOCKS-1:0]        single_access_ram_sel_o,
  output logic [MMDEC_ROM_BLOCKS-1:0]       rom_sel_o,
  output logic [MMDEC_EXT_SELS-1:0]         ext_select_line_o,
  output logic [MMDEC_EXT_ABITS-1:0]        ext_addr_o,
  output logic                              ext_byte_o,
  output logic [MMDEC_IO_WINS-1:0]          io_sel_o,
  output logic                              wr_en_o,
  output logic [15:0]                       wdata_o
);
  logic                        rom_unmap_bit;
  logic [MMDEC_IO_WINS-1:0]    io_win;
  logic [MMDEC_IO_WINS-1:0]    io_allow;
  mmdec_master_e               master;
  mmdec_dest_e                 next_dest;
  logic [MMDEC_EXT_SELS-1:0]   next_ext;
  logic                        next_deny;
  logic                        next_hit;
  logic                        is_dma;
  logic                        rd_pend;

  assign master = mmdec_master_e'(master_i);
  assign is_dma = (master == MMDEC_M_DMA0) || (master == MMDEC_M_DMA1) ||
                  (master == MMDEC_M_DMA2) || (master == MMDEC_M_DMA3);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rom_unmap_bit <= MMDEC_UNMAP_RST;
    end else if (unmap_wr_i) begin
      rom_unmap_bit <= unmap_val_i;
    end
  end

  mmdec_io_decode u_io (
    .addr_i (addr_i[15:0]),
    .win_o  (io_win)
  );

  // DMA-reachable peripherals
  // Reachable: memory port 5, I2C 10, UART 11, audio 13-15, serial 18, 21-22,
  // cards 19-20, USB 23; the analog window has no index and is accepted below
  always_comb begin
    io_allow = '1;
    if (is_dma) begin
      io_allow = '0;
      io_allow[5]  = 1'b1;
      io_allow[10] = 1'b1;
      io_allow[11] = 1'b1;
      io_allow[13] = 1'b1;
      io_allow[14] = 1'b1;
      io_allow[15] = 1'b1;
      io_allow[18] = 1'b1;
      io_allow[19] = 1'b1;
      io_allow[20] = 1'b1;
      io_allow[21] = 1'b1;
      io_allow[22] = 1'b1;
      io_allow[23] = 1'b1;
    end
  end

  // Analog window sits in the USB-free gap; decoded here only to accept the access, it drives no io_sel_o bit
  logic io_adc;
  assign io_adc = (addr_i[15:0] >= MMDEC_IO_ADC_LO) && (addr_i[15:0] <= MMDEC_IO_ADC_HI);

  // Memory-space destination decode
  always_comb begin
    next_dest = MMDEC_D_NONE;
    next_ext  = '0;
    if (addr_i >= MMDEC_ROM_BASE) begin
      if (!rom_unmap_bit) begin
        next_dest = MMDEC_D_ROM;
      end else begin
        next_dest   = MMDEC_D_EXT;
        next_ext[4] = 1'b1;
      end
    end else if (addr_i >= MMDEC_EXT_BASE) begin
      next_dest = MMDEC_D_EXT;
      if (addr_i >= MMDEC_CS5_BASE) begin
        next_ext[4] = 1'b1;
      end else if (addr_i >= MMDEC_CS4_BASE) begin
        next_ext[3] = 1'b1;
      end else if (addr_i >= MMDEC_CS3_BASE) begin
        next_ext[2] = 1'b1;
      end else if (addr_i >= MMDEC_CS2_BASE) begin
        next_ext[1] = 1'b1;
      end else begin
        next_ext[0] = 1'b1;
      end
    end else if (addr_i >= MMDEC_SINGLE_ACCESS_RAM_BASE) begin
      next_dest = MMDEC_D_SINGLE_ACCESS_RAM;
    end else if (addr_i >= MMDEC_DUAL_ACCESS_RAM_BASE) begin
      next_dest = MMDEC_D_DUAL_ACCESS_RAM;
    end
  end

  // Access permissions per master
  always_comb begin
    next_deny = 1'b0;
    if (io_space_i) begin
      // only CPU I/O opcodes or DMA
      next_deny = !((master == MMDEC_M_CPU) || is_dma) ||
                  !(|(io_win & io_allow) || io_adc);
    end else begin
      unique case (next_dest)
        MMDEC_D_NONE:  next_deny = 1'b1;
        // no dual-access RAM for USB or host
        MMDEC_D_DUAL_ACCESS_RAM: next_deny = (master == MMDEC_M_USB) || (master == MMDEC_M_HOST);
        MMDEC_D_SINGLE_ACCESS_RAM: next_deny = 1'b0;
        MMDEC_D_ROM:   next_deny = (master != MMDEC_M_CPU) || we_i;
        MMDEC_D_EXT:   next_deny = (master == MMDEC_M_DMA0) || (master == MMDEC_M_DMA1) ||
                                   (master == MMDEC_M_DMA2);
        default:       next_deny = 1'b1;
      endcase
      if (prog_bus_i && (master != MMDEC_M_CPU)) begin
        next_deny = 1'b1;
      end
    end
    next_hit = req_i && !next_deny;
  end

  // Registered selects
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dual_access_ram_sel_o       <= '0;
      single_access_ram_sel_o       <= '0;
      rom_sel_o         <= '0;
      ext_select_line_o <= '0;
      io_sel_o          <= '0;
    end else begin
      dual_access_ram_sel_o       <= '0;
      single_access_ram_sel_o       <= '0;
      rom_sel_o         <= '0;
      ext_select_line_o <= '0;
      io_sel_o          <= '0;
      if (next_hit && io_space_i) begin
        io_sel_o <= io_win;
      end else if (next_hit) begin
        unique case (next_dest)
          MMDEC_D_DUAL_ACCESS_RAM: dual_access_ram_sel_o[addr_i[15:MMDEC_BLK_SHIFT]] <= 1'b1;
          MMDEC_D_SINGLE_ACCESS_RAM: single_access_ram_sel_o[5'(addr_i[18:MMDEC_BLK_SHIFT] - 6'd8)] <= 1'b1;
          MMDEC_D_ROM:   rom_sel_o[addr_i[16:MMDEC_ROM_SHIFT]] <= 1'b1;
          MMDEC_D_EXT: begin
            ext_select_line_o <= next_ext | {3'b000, next_ext[0] & sdram_dual_sel_i, 1'b0};
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_addr_o <= '0;
      ext_byte_o <= 1'b0;
    end else begin
      ext_byte_o <= ext_byte_mode_i || (EXT_DBITS == 8);
      if (next_hit && !io_space_i && (next_dest == MMDEC_D_EXT)) begin
        ext_addr_o <= ext_byte_mode_i ? addr_i[MMDEC_EXT_ABITS-1:0]
                                      : addr_i[MMDEC_EXT_ABITS:1];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_en_o <= 1'b0;
      wdata_o <= '0;
    end else begin
      wr_en_o <= next_hit && we_i;
      if (next_hit && we_i) begin
        wdata_o <= wdata_i;
      end
    end
  end

  // Handshake: answer one cycle after request
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o   <= 1'b0;
      deny_o  <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      ack_o   <= req_i;
      deny_o  <= req_i && next_deny;
      rd_pend <= next_hit && !we_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_pend ? tgt_rdata_i : '0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rom_unmap_bit_o <= MMDEC_UNMAP_RST;
    end else begin
      rom_unmap_bit_o <= rom_unmap_bit;
    end
  end

  // Sequences used by the checks
  sequence rom_req_s;
    req_i && !io_space_i && (master == MMDEC_M_CPU) && !we_i && (addr_i >= MMDEC_ROM_BASE);
  endsequence

  rom_mapped_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rom_req_s and !rom_unmap_bit |=> (|rom_sel_o) && !ext_select_line_o[4])
    else $error("ROM range not routed to ROM");
  rom_unmapped_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rom_req_s and rom_unmap_bit |=> ext_select_line_o[4] && (rom_sel_o == '0))
    else $error("Unmapped ROM range not on select five");
  unmap_reset_a: assert property (@(posedge clk_i)
    !resetn_i ##1 !resetn_i |-> !rom_unmap_bit)
    else $error("Unmap bit not cleared by reset");
  unmap_soft_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    soft_reset_i && !unmap_wr_i |=> $stable(rom_unmap_bit))
    else $error("Soft reset changed unmap bit");
  dma_ext_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i && !io_space_i && (addr_i >= MMDEC_EXT_BASE) &&
    (master_i inside {3'd1, 3'd2, 3'd3}) |=> deny_o && (ext_select_line_o == '0))
    else $error("DMA0-2 reached external space");
  dual_access_ram_deny_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i && !io_space_i && (master_i inside {3'd5, 3'd6}) && (addr_i < MMDEC_SINGLE_ACCESS_RAM_BASE)
    |=> deny_o && (dual_access_ram_sel_o == '0))
    else $error("USB or host reached dual-access RAM");
  mmr_reserved_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i && !io_space_i && (addr_i < MMDEC_DUAL_ACCESS_RAM_BASE) |=> deny_o && (dual_access_ram_sel_o == '0))
    else $error("Reserved low bytes selected RAM");
  sdram_sel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    next_hit && !io_space_i && (next_dest == MMDEC_D_EXT) && next_ext[0]
    |=> ext_select_line_o[0] && (ext_select_line_o[1] == $past(sdram_dual_sel_i)))
    else $error("SDRAM select pairing wrong");
  reserved_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i && next_deny |=> !wr_en_o ##1 (rdata_o == '0))
    else $error("Refused access not silent");
  usb_io_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i && io_space_i && (master == MMDEC_M_CPU) && addr_i[15] |=> io_sel_o[23])
    else $error("USB window not selected");
  ack_req_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i |=> ack_o)
    else $error("Request not answered");
  host_io_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i && io_space_i && (master_i inside {3'd5, 3'd6}) |=> deny_o && (io_sel_o == '0))
    else $error("Host or USB reached I/O space");
  dma_io_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i && io_space_i && is_dma && io_win[12] |=> deny_o && (io_sel_o == '0))
    else $error("DMA reached system control");
  io_onehot_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $onehot0(io_sel_o))
    else $error("Several I/O windows selected");
  ext_onehot_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $onehot0({ext_select_line_o[4:2], ext_select_line_o[0]}))
    else $error("Several external spaces selected");
  rom_onehot_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $onehot0(rom_sel_o))
    else $error("Several ROM blocks selected");
  da_onehot_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $onehot0(dual_access_ram_sel_o))
    else $error("Several dual-access blocks selected");
  sa_onehot_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $onehot0(single_access_ram_sel_o))
    else $error("Several single-access blocks selected");
  byte_mode_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ext_byte_mode_i |=> ext_byte_o)
    else $error("Byte mode not shown");
  deny_quiet_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    deny_o |-> (dual_access_ram_sel_o == '0) && (single_access_ram_sel_o == '0) && (rom_sel_o == '0) &&
               (ext_select_line_o == '0) && (io_sel_o == '0) && !wr_en_o)
    else $error("Refused access still selected a target");
  ext_hit_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    next_hit && !io_space_i && (next_dest == MMDEC_D_EXT) |=> (ext_select_line_o != '0))
    else $error("External access without select");
endmodule : mmdec_top

// File: hdl/mmdec_pkg.sv
// Constants and types for the memory map decoder
package mmdec_pkg;
  // Byte map of the unified 24-bit space
  localparam logic [23:0] MMDEC_MMR_BASE   = 24'h00_0000;
  localparam logic [23:0] MMDEC_DUAL_ACCESS_RAM_BASE = 24'h00_00C0;
  localparam logic [23:0] MMDEC_SINGLE_ACCESS_RAM_BASE = 24'h01_0000;
  localparam logic [23:0] MMDEC_EXT_BASE   = 24'h05_0000;
  localparam logic [23:0] MMDEC_CS2_BASE   = 24'h80_0000;
  localparam logic [23:0] MMDEC_CS3_BASE   = 24'hC0_0000;
  localparam logic [23:0] MMDEC_CS4_BASE   = 24'hE0_0000;
  localparam logic [23:0] MMDEC_CS5_BASE   = 24'hF0_0000;
  localparam logic [23:0] MMDEC_ROM_BASE   = 24'hFE_0000;
  localparam logic [23:0] MMDEC_ROM_LAST   = 24'hFF_FFFF;
  // RAM block geometry: 8K-byte blocks
  localparam int          MMDEC_BLK_SHIFT  = 13;
  localparam int          MMDEC_DA_BLOCKS  = 8;
  localparam int          MMDEC_SA_BLOCKS  = 32;
  // ROM: four 16K-word blocks, 32K bytes each
  localparam int          MMDEC_ROM_SHIFT  = 15;
  localparam int          MMDEC_ROM_BLOCKS = 4;
  // External port geometry
  localparam int          MMDEC_EXT_ABITS  = 21;
  localparam int          MMDEC_EXT_SELS   = 5;
  // I/O word windows
  localparam logic [15:0] MMDEC_IO_IDLE_LO = 16'h0000;
  localparam logic [15:0] MMDEC_IO_IDLE_HI = 16'h0004;
  localparam logic [15:0] MMDEC_IO_DMA0_LO = 16'h0C00;
  localparam logic [15:0] MMDEC_IO_DMA0_HI = 16'h0C7F;
  localparam logic [15:0] MMDEC_IO_DMA1_LO = 16'h0D00;
  localparam logic [15:0] MMDEC_IO_DMA1_HI = 16'h0D7F;
  localparam logic [15:0] MMDEC_IO_DMA2_LO = 16'h0E00;
  localparam logic [15:0] MMDEC_IO_DMA2_HI = 16'h0E7F;
  localparam logic [15:0] MMDEC_IO_DMA3_LO = 16'h0F00;
  localparam logic [15:0] MMDEC_IO_DMA3_HI = 16'h0F7F;
  localparam logic [15:0] MMDEC_IO_EXTERNAL_MEMORY_PORT_LO = 16'h1000;
  localparam logic [15:0] MMDEC_IO_EXTERNAL_MEMORY_PORT_HI = 16'h10DD;
  localparam logic [15:0] MMDEC_IO_TIM0_LO = 16'h1800;
  localparam logic [15:0] MMDEC_IO_TIM0_HI = 16'h181F;
  localparam logic [15:0] MMDEC_IO_TIM1_LO = 16'h1840;
  localparam logic [15:0] MMDEC_IO_TIM1_HI = 16'h185F;
  localparam logic [15:0] MMDEC_IO_TIM2_LO = 16'h1880;
  localparam logic [15:0] MMDEC_IO_TIM2_HI = 16'h189F;
  localparam logic [15:0] MMDEC_IO_RTC_LO  = 16'h1900;
  localparam logic [15:0] MMDEC_IO_RTC_HI  = 16'h197F;
  localparam logic [15:0] MMDEC_IO_I2C_LO  = 16'h1A00;
  localparam logic [15:0] MMDEC_IO_I2C_HI  = 16'h1A6C;
  localparam logic [15:0] MMDEC_IO_UART_LO = 16'h1B00;
  localparam logic [15:0] MMDEC_IO_UART_HI = 16'h1B1F;
  localparam logic [15:0] MMDEC_IO_SYS_LO  = 16'h1C00;
  localparam logic [15:0] MMDEC_IO_SYS_HI  = 16'h1CFF;
  localparam logic [15:0] MMDEC_IO_AUD0_LO = 16'h2800;
  localparam logic [15:0] MMDEC_IO_AUD0_HI = 16'h2840;
  localparam logic [15:0] MMDEC_IO_AUD2_LO = 16'h2A00;
  localparam logic [15:0] MMDEC_IO_AUD2_HI = 16'h2A40;
  localparam logic [15:0] MMDEC_IO_AUD3_LO = 16'h2B00;
  localparam logic [15:0] MMDEC_IO_AUD3_HI = 16'h2B40;
  localparam logic [15:0] MMDEC_IO_HOST_LO = 16'h2E00;
  localparam logic [15:0] MMDEC_IO_HOST_HI = 16'h2E81;
  localparam logic [15:0] MMDEC_IO_SPI_LO  = 16'h3000;
  localparam logic [15:0] MMDEC_IO_SPI_HI  = 16'h300F;
  localparam logic [15:0] MMDEC_IO_MSP_LO  = 16'h3400;
  localparam logic [15:0] MMDEC_IO_MSP_HI  = 16'h3749;
  localparam logic [15:0] MMDEC_IO_CRD0_LO = 16'h3A00;
  localparam logic [15:0] MMDEC_IO_CRD0_HI = 16'h3A7F;
  localparam logic [15:0] MMDEC_IO_CRD1_LO = 16'h3B00;
  localparam logic [15:0] MMDEC_IO_CRD1_HI = 16'h3B7F;
  localparam logic [15:0] MMDEC_IO_BSP_LO  = 16'h4000;
  localparam logic [15:0] MMDEC_IO_BSP_HI  = 16'h407F;
  localparam logic [15:0] MMDEC_IO_BSPD_LO = 16'h6000;
  localparam logic [15:0] MMDEC_IO_BSPD_HI = 16'h60FF;
  localparam logic [15:0] MMDEC_IO_ADC_LO  = 16'h7000;
  localparam logic [15:0] MMDEC_IO_ADC_HI  = 16'h70FF;
  localparam logic [15:0] MMDEC_IO_USB_LO  = 16'h8000;
  localparam logic [15:0] MMDEC_IO_USB_HI  = 16'hFFFF;
  localparam int          MMDEC_IO_WINS    = 24;
  // Reset value of the ROM-unmap bit
  localparam logic        MMDEC_UNMAP_RST  = 1'b0;

  // Requesting master
  typedef enum logic [2:0] {
    MMDEC_M_CPU, MMDEC_M_DMA0, MMDEC_M_DMA1, MMDEC_M_DMA2,
    MMDEC_M_DMA3, MMDEC_M_HOST, MMDEC_M_USB
  } mmdec_master_e;

  // Destination of a memory-space access
  typedef enum logic [2:0] {
    MMDEC_D_NONE, MMDEC_D_DUAL_ACCESS_RAM, MMDEC_D_SINGLE_ACCESS_RAM, MMDEC_D_ROM, MMDEC_D_EXT
  } mmdec_dest_e;
endpackage : mmdec_pkg

// File: hdl/mmdec_io_decode.sv
// I/O-space window decoder: one-hot window select for a word address
`timescale 1ns/1ps
module mmdec_io_decode
  import mmdec_pkg::*;
(
  input  wire logic [15:0]               addr_i,
  output logic      [MMDEC_IO_WINS-1:0]  win_o
);
  localparam logic [15:0] WIN_LO [MMDEC_IO_WINS] = '{
    MMDEC_IO_IDLE_LO, MMDEC_IO_DMA0_LO, MMDEC_IO_DMA1_LO, MMDEC_IO_DMA2_LO,
    MMDEC_IO_DMA3_LO, MMDEC_IO_EXTERNAL_MEMORY_PORT_LO, MMDEC_IO_TIM0_LO, MMDEC_IO_TIM1_LO,
    MMDEC_IO_TIM2_LO, MMDEC_IO_RTC_LO,  MMDEC_IO_I2C_LO,  MMDEC_IO_UART_LO,
    MMDEC_IO_SYS_LO,  MMDEC_IO_AUD0_LO, MMDEC_IO_AUD2_LO, MMDEC_IO_AUD3_LO,
    MMDEC_IO_HOST_LO, MMDEC_IO_SPI_LO,  MMDEC_IO_MSP_LO,  MMDEC_IO_CRD0_LO,
    MMDEC_IO_CRD1_LO, MMDEC_IO_BSP_LO,  MMDEC_IO_BSPD_LO, MMDEC_IO_USB_LO};
  localparam logic [15:0] WIN_HI [MMDEC_IO_WINS] = '{
    MMDEC_IO_IDLE_HI, MMDEC_IO_DMA0_HI, MMDEC_IO_DMA1_HI, MMDEC_IO_DMA2_HI,
    MMDEC_IO_DMA3_HI, MMDEC_IO_EXTERNAL_MEMORY_PORT_HI, MMDEC_IO_TIM0_HI, MMDEC_IO_TIM1_HI,
    MMDEC_IO_TIM2_HI, MMDEC_IO_RTC_HI,  MMDEC_IO_I2C_HI,  MMDEC_IO_UART_HI,
    MMDEC_IO_SYS_HI,  MMDEC_IO_AUD0_HI, MMDEC_IO_AUD2_HI, MMDEC_IO_AUD3_HI,
    MMDEC_IO_HOST_HI, MMDEC_IO_SPI_HI,  MMDEC_IO_MSP_HI,  MMDEC_IO_CRD0_HI,
    MMDEC_IO_CRD1_HI, MMDEC_IO_BSP_HI,  MMDEC_IO_BSPD_HI, MMDEC_IO_USB_HI};

  // Windows never overlap, so the result is one-hot or zero
  for (genvar w = 0; w < MMDEC_IO_WINS; w++) begin : g_win
    assign win_o[w] = (addr_i >= WIN_LO[w]) && (addr_i <= WIN_HI[w]);
  end
endmodule : mmdec_io_decode

// File: tb/mmdec_target_model.sv
// Target-side read data source for the decoder bench
`timescale 1ns/1ps
module mmdec_target_model (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  output logic      [15:0] tgt_rdata_o
);
  // New word every cycle, so a capture on the wrong edge shows as a mismatch
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tgt_rdata_o <= 16'hA5C3;
    end else begin
      tgt_rdata_o <= {tgt_rdata_o[14:0], ^(tgt_rdata_o & 16'hB400)};
    end
  end
endmodule : mmdec_target_model

// File: tb/tb_memory_map_decoder.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module tb_memory_map_decoder;
  import mmdec_pkg::*;
  logic        clk_i = 0, resetn_i = 0, unmap_wr_i = 0, unmap_val_i = 0;
  logic        soft_reset_i = 0, ext_byte_mode_i = 0, sdram_dual_sel_i = 0;
  logic        req_i = 0, we_i = 0, io_space_i = 0, prog_bus_i = 0;
  logic [2:0]  master_i = 0;
  logic [23:0] addr_i = 0;
  logic [15:0] wdata_i = 0, tgt_rdata_i, rdata_o, wdata_o;
  logic        rom_unmap_bit_o, ack_o, deny_o, ext_byte_o, wr_en_o;
  logic [7:0]  dual_access_ram_sel_o, p_da;
  logic [31:0] single_access_ram_sel_o, p_sa;
  logic [3:0]  rom_sel_o, p_rom;
  logic [4:0]  ext_select_line_o;
  logic [20:0] ext_addr_o, p_xa;
  logic [23:0] io_sel_o, p_io;
  logic [15:0] p_wd, r_rd;
  logic        p_v = 0, r_v = 0, p_dny, p_we, p_ext, p_sd, p_c2, unmap_q = 0;
  int          checks = 0, bad_count = 0;
  logic [15:0] ioa [16] = '{16'h0000, 16'h0005, 16'h0C00, 16'h0C7F, 16'h0C80, 16'h1C00,
                            16'h1CFF, 16'h7000, 16'h8000, 16'h7100, 16'h8000, 16'hFFFF,
                            16'h8000, 16'h1B00, 16'h1C00, 16'h1000};
  logic [2:0]  iom [16] = '{0, 0, 0, 0, 0, 0, 2, 0, 6, 0, 0, 0, 4, 4, 5, 4};
  int          iow [16] = '{0, -1, 1, 1, -1, 12, -1, 24, -1, -1, 23, 23, 23, 11, -1, 5};
  logic [23:0] bases [8] = '{24'h00_0000, 24'h01_0000, 24'h04_0000, 24'h05_0000,
                             24'h80_0000, 24'hC0_0000, 24'hE0_0000, 24'hFE_0000};

  always #2.5 clk_i = ~clk_i;

  mmdec_top uut (.clk_i, .resetn_i, .unmap_wr_i, .unmap_val_i, .soft_reset_i,
    .ext_byte_mode_i, .sdram_dual_sel_i, .req_i, .we_i, .io_space_i, .prog_bus_i,
    .master_i, .addr_i, .wdata_i, .tgt_rdata_i, .rom_unmap_bit_o, .ack_o, .deny_o,
    .rdata_o, .dual_access_ram_sel_o, .single_access_ram_sel_o, .rom_sel_o, .ext_select_line_o, .ext_addr_o,
    .ext_byte_o, .io_sel_o, .wr_en_o, .wdata_o);

  mmdec_target_model partner (.clk_i, .resetn_i, .tgt_rdata_o(tgt_rdata_i));

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic print_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // One cycle: judge the last two requests, then predict and launch the next
  task automatic step(input bit v, input logic [2:0] m, input logic [23:0] a, input bit w,
                      input bit io, input bit prg, input int iw);
    bit dr, sr, rm, ex, d;
    @(posedge clk_i);
    #1;
    if (p_v) begin
      cmp("ack", 1, ack_o);
      cmp("deny", p_dny, deny_o);
      cmp("dual_access_ram", p_da, dual_access_ram_sel_o);
      cmp("single_access_ram", p_sa, single_access_ram_sel_o);
      cmp("rom", p_rom, rom_sel_o);
      cmp("io", p_io, io_sel_o);
      cmp("ext", p_ext, |ext_select_line_o);
      cmp("wr", p_we && !p_dny, wr_en_o);
      if (p_ext) begin
        cmp("sd0", p_sd, ext_select_line_o[0]);
        cmp("sd1", (p_sd && sdram_dual_sel_i) || p_c2, ext_select_line_o[1]);
        cmp("xaddr", p_xa, ext_addr_o);
      end
      if (wr_en_o === 1'b1) cmp("wdata", p_wd, wdata_o);
    end else cmp("idle", 0, {ack_o, deny_o, wr_en_o});
    if (r_v) cmp("rdata", r_rd, rdata_o);
    r_v = p_v;
    // Target word stands from the edge that takes the request
    r_rd = (p_dny || p_we) ? 16'h0000 : tgt_rdata_i;
    dr = !io && a >= 24'h00_00C0 && a < 24'h01_0000;
    sr = !io && a >= 24'h01_0000 && a < 24'h05_0000;
    rm = !io && a >= 24'hFE_0000 && !unmap_q;
    ex = !io && a >= 24'h05_0000 && !rm;
    d = io ? iw < 0 : (a < 24'h00_00C0) || (ex && m inside {1, 2, 3}) || (dr && m >= 5)
        || (rm && (m != 0 || w)) || (prg && m != 0);
    p_dny = d;
    p_da = (dr && !d) ? 8'b1 << a[15:13] : 8'h00;
    p_sa = (sr && !d) ? 32'b1 << ((a - 24'h01_0000) >> 13) : 32'h0000_0000;
    p_rom = (rm && !d) ? 4'b1 << a[16:15] : 4'h0;
    p_io = (io && !d && iw < 24) ? 24'b1 << iw : 24'h00_0000;
    p_ext = ex && !d;
    p_sd = a < 24'h80_0000;
    p_c2 = a >= 24'h80_0000 && a < 24'hC0_0000;
    p_xa = ext_byte_mode_i ? a[20:0] : a[21:1];
    p_we = w;
    p_v = v;
    req_i = v;
    master_i = m;
    addr_i = a;
    we_i = w;
    io_space_i = io;
    prog_bus_i = prg;
    wdata_i = 16'($urandom);
    p_wd = wdata_i;
  endtask : step

  task automatic flush;
    repeat (2) step(0, 0, 24'h00_0000, 0, 0, 0, 0);
  endtask : flush

  // Random masters over all regions except the F00000h select-five space, with region edges mixed in
  task automatic mem_phase(input int n);
    logic [23:0] a;
    logic [2:0]  m;
    for (int i = 0; i < n; i++) begin
      a = bases[$urandom % 8] + 24'($urandom % 32'h0002_0000);
      if ($urandom % 4 == 0) a = bases[$urandom % 8] - 24'($urandom % 2);
      m = 3'($urandom % 7);
      step($urandom % 5 != 0, m, a, $urandom % 2, 0, $urandom % 6 == 0, 0);
    end
    flush;
  endtask : mem_phase

  task automatic set_unmap(input bit b);
    @(posedge clk_i);
    #1 unmap_wr_i = 1;
    unmap_val_i = b;
    @(posedge clk_i);
    #1 unmap_wr_i = 0;
    unmap_q = b;
    repeat (2) @(posedge clk_i);
    #1 cmp("unmap", b, rom_unmap_bit_o);
  endtask : set_unmap

  initial begin
    void'($urandom(82110));
    repeat (10) @(posedge clk_i);
    #1 resetn_i = 1;
    @(posedge clk_i);
    #1 cmp("rst", 0, {rom_unmap_bit_o, ack_o, deny_o, rom_sel_o, ext_select_line_o});
    mem_phase(400);
    // reserved words only as refusal probes; peripherals taken as released
    for (int i = 0; i < 16; i++) step(1, iom[i], {8'h00, ioa[i]}, $urandom % 2, 1, 0, iow[i]);
    flush;
    set_unmap(1);
    sdram_dual_sel_i = 1;
    ext_byte_mode_i = 1;
    mem_phase(400);
    cmp("byte", 1, ext_byte_o);
    soft_reset_i = 1;
    @(posedge clk_i);
    #1 soft_reset_i = 0;
    repeat (2) @(posedge clk_i);
    #1 cmp("soft", 1, rom_unmap_bit_o);
    resetn_i = 0;
    repeat (3) @(posedge clk_i);
    #1 resetn_i = 1;
    unmap_q = 0;
    sdram_dual_sel_i = 0;
    @(posedge clk_i);
    #1 cmp("hwrst", 0, rom_unmap_bit_o);
    mem_phase(200);
    print_verdict;
  end

  initial begin
    for (int i = 0; i < 20000; i++) @(posedge clk_i);
    bad_count++;
    print_verdict;
  end
endmodule : tb_memory_map_decoder
